/* ram_rdw_pkg.sv */
// Shared constants, modes and defaults of the block RAM read-during-write model.
package ram_rdw_pkg;

    // ------------------------------------------------------------------
    // Geometry defaults
    // ------------------------------------------------------------------
    localparam int data_w_def = 18;
    localparam int addr_w_def = 9;
    localparam int byte_w_def = 9;
    localparam int port_count = 2;

    // ------------------------------------------------------------------
    // Reset and power-up values
    // ------------------------------------------------------------------
    localparam logic out_reset_bit = 1'b0;
    localparam logic mem_reset_bit = 1'b0;
    localparam logic flag_reset_bit = 1'b0;

    // ------------------------------------------------------------------
    // Memory configurations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        cfg_single_port = 3'b001,
        cfg_simple_dual = 3'b010,
        cfg_true_dual = 3'b100
    } ram_cfg_e;

    // ------------------------------------------------------------------
    // Clock modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        clk_single = 4'b0001,
        clk_in_out = 4'b0010,
        clk_read_write = 4'b0100,
        clk_independent = 4'b1000
    } clk_mode_e;

    // ------------------------------------------------------------------
    // Read-during-write output choices
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        same_new_data = 3'b001,
        same_old_data = 3'b010,
        same_dont_care = 3'b100
    } same_rdw_e;

    typedef enum logic [1:0] {
        mixed_old_data = 2'b01,
        mixed_dont_care = 2'b10
    } mixed_rdw_e;

    // ------------------------------------------------------------------
    // Device configuration image modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        img_comp_with_init = 4'b0001,
        img_uncomp_with_init = 4'b0010,
        img_comp_plain = 4'b0100,
        img_dual_comp = 4'b1000
    } image_mode_e;

endpackage

/* ram_port_if.sv */
// Carrier between the array core and one port's output stage.
`timescale 1ns/10ps
interface ram_port_if #(
    parameter int data_w = ram_rdw_pkg::data_w_def
);
    logic in_ce;
    logic re;
    logic out_ce;
    logic aclr;
    logic [data_w-1:0] rd_word;
    logic [data_w-1:0] q;

    modport core (
        output in_ce,
        output re,
        output out_ce,
        output aclr,
        output rd_word,
        input q
    );

    modport stage (
        input in_ce,
        input re,
        input out_ce,
        input aclr,
        input rd_word,
        output q
    );
endinterface

/* ram_port.sv */
// Output stage of one RAM port: read latch, optional output register, clears.
`timescale 1ns/10ps
module ram_port #(
    parameter bit out_reg = 1'b1,
    parameter int data_w = ram_rdw_pkg::data_w_def
)(
    input wire logic clock,
    input wire logic nrst,
    ram_port_if.stage bus
);
    import ram_rdw_pkg::*;

    logic [data_w-1:0] read_latch;
    logic [data_w-1:0] q_reg;
    wire logic take_read;

    // A read is only captured when the input group is enabled and the read is asked for.
    assign take_read = bus.in_ce & bus.re;

    // Read latch; the clear touches only output-side storage, never the array.
    always_ff @(posedge clock or posedge bus.aclr) begin
        if (bus.aclr) begin
            read_latch <= {data_w{out_reset_bit}};
        end else if (!nrst) begin
            read_latch <= {data_w{out_reset_bit}};
        end else if (take_read) begin
            read_latch <= bus.rd_word;
        end
    end

    // Output register; frozen independently of the input group to save power.
    always_ff @(posedge clock or posedge bus.aclr) begin
        if (bus.aclr) begin
            q_reg <= {data_w{out_reset_bit}};
        end else if (!nrst) begin
            q_reg <= {data_w{out_reset_bit}};
        end else if (bus.out_ce) begin
            q_reg <= read_latch;
        end
    end

    // Bypassed output register still shows a flip-flop: the read latch.
    assign bus.q = out_reg ? q_reg : read_latch;
endmodule

/* block_ram_rdw.sv */
// Embedded block RAM with configurable read-during-write behaviour.
//
// Summary of operation
// - New-data mode: written word shows same edge.
// - Byte enables mix new and old lanes.
// - Same-port don't-care returns the old word.
// - Mixed collision: one port writes, other reads.
// - Mixed old-data mode returns the prior word.
// - Mixed don't-care mode drives unknown.
// - Shared clock mixed old-data collision returns old word.
// - Different clocks make mixed collision unknown.
// - Outputs power up cleared, even when preloaded.
// - Array starts zero unless preload supplied.
// - Preload needs init image mode, flash variant.
// - Separate input and output clock enables.
// - Single-port: same-port only, single or in/out.
// - Simple dual: mixed only, single or in/out.
// - True dual: clock modes per collision type.
// - Only the listed output choices are legal.
// - Clear acts only on output storage.
// - Read/write clock collision reads unknown.
`timescale 1ns/10ps
module block_ram_rdw #(
    parameter int data_w = ram_rdw_pkg::data_w_def,
    parameter int addr_w = ram_rdw_pkg::addr_w_def,
    parameter int byte_w = ram_rdw_pkg::byte_w_def,
    parameter ram_rdw_pkg::ram_cfg_e cfg = ram_rdw_pkg::cfg_true_dual,
    parameter ram_rdw_pkg::clk_mode_e clk_mode = ram_rdw_pkg::clk_single,
    parameter ram_rdw_pkg::same_rdw_e same_rdw_a = ram_rdw_pkg::same_new_data,
    parameter ram_rdw_pkg::same_rdw_e same_rdw_b = ram_rdw_pkg::same_new_data,
    parameter ram_rdw_pkg::mixed_rdw_e mixed_rdw = ram_rdw_pkg::mixed_old_data,
    parameter bit out_reg_a = 1'b1,
    parameter bit out_reg_b = 1'b1,
    parameter ram_rdw_pkg::image_mode_e image_mode = ram_rdw_pkg::img_comp_with_init,
    parameter bit flash_analog = 1'b1,
    parameter bit preload_en = 1'b0,
    parameter logic [(2**addr_w)*data_w-1:0] preload = '0
)(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [addr_w-1:0] a_addr,
    input wire logic [data_w-1:0] a_wdata,
    input wire logic [data_w/byte_w-1:0] a_be,
    input wire logic a_we,
    input wire logic a_re,
    input wire logic a_in_ce,
    input wire logic a_out_ce,
    input wire logic a_aclr,
    output logic [data_w-1:0] a_q,
    input wire logic [addr_w-1:0] b_addr,
    input wire logic [data_w-1:0] b_wdata,
    input wire logic [data_w/byte_w-1:0] b_be,
    input wire logic b_we,
    input wire logic b_re,
    input wire logic b_in_ce,
    input wire logic b_out_ce,
    input wire logic b_aclr,
    output logic [data_w-1:0] b_q,
    output logic write_conflict,
    output logic rdw_supported,
    output logic preload_applied
);
    import ram_rdw_pkg::*;

    localparam int depth = 2**addr_w;
    localparam int lanes = data_w / byte_w;

    // ------------------------------------------------------------------
    // Lane merge
    // ------------------------------------------------------------------

    // Enabled lanes take the new data, disabled lanes keep what is stored.
    function automatic logic [data_w-1:0] lane_merge(
        input logic [data_w-1:0] old_word,
        input logic [data_w-1:0] new_word,
        input logic [lanes-1:0] enables
    );
        logic [data_w-1:0] result;
        result = old_word;
        for (int l = 0; l < lanes; l++) begin
            if (enables[l]) begin
                result[l*byte_w +: byte_w] = new_word[l*byte_w +: byte_w];
            end
        end
        return result;
    endfunction

    // ------------------------------------------------------------------
    // Port request arrays
    // ------------------------------------------------------------------
    logic [addr_w-1:0] addr [port_count];
    logic [data_w-1:0] wdata [port_count];
    logic [lanes-1:0] be [port_count];
    logic we_raw [port_count];
    logic re_raw [port_count];
    logic in_ce [port_count];
    logic out_ce [port_count];
    logic aclr [port_count];
    logic can_write [port_count];
    logic can_read [port_count];
    logic we_eff [port_count];
    logic re_eff [port_count];
    logic [data_w-1:0] stored [port_count];
    logic [data_w-1:0] merged [port_count];
    logic [data_w-1:0] rd_word [port_count];
    same_rdw_e same_mode [port_count];

    // Fold the two named port groups into arrays so the per-port logic is one loop.
    assign addr[0] = a_addr;
    assign addr[1] = b_addr;
    assign wdata[0] = a_wdata;
    assign wdata[1] = b_wdata;
    assign be[0] = a_be;
    assign be[1] = b_be;
    assign we_raw[0] = a_we;
    assign we_raw[1] = b_we;
    assign re_raw[0] = a_re;
    assign re_raw[1] = b_re;
    assign in_ce[0] = a_in_ce;
    assign in_ce[1] = b_in_ce;
    assign out_ce[0] = a_out_ce;
    assign out_ce[1] = b_out_ce;
    assign aclr[0] = a_aclr;
    assign aclr[1] = b_aclr;
    assign same_mode[0] = same_rdw_a;
    assign same_mode[1] = same_rdw_b;

    // ------------------------------------------------------------------
    // Configuration roles
    // ------------------------------------------------------------------

    // Single-port uses port A alone; simple dual writes on A and reads on B.
    // Requests a configuration has no use for are ignored rather than flagged.
    assign can_write[0] = 1'b1;
    assign can_write[1] = (cfg == cfg_true_dual);
    assign can_read[0] = (cfg != cfg_simple_dual);
    assign can_read[1] = (cfg != cfg_single_port);

    // ------------------------------------------------------------------
    // Clock mode and output choice legality
    // ------------------------------------------------------------------
    wire logic clk_shared;
    wire logic same_clk_ok;
    wire logic mixed_clk_ok;
    wire logic same_sel_ok;
    wire logic cfg_clk_ok;
    wire logic preload_ok;

    // Ports share one edge only in single and input/output clock modes.
    assign clk_shared = (clk_mode == clk_single) || (clk_mode == clk_in_out);
    assign same_clk_ok = clk_shared ||
        ((cfg == cfg_true_dual) && (clk_mode == clk_independent));
    assign mixed_clk_ok = clk_shared;

    // True dual same-port offers only new or old data; the other cases take all.
    assign same_sel_ok = (cfg != cfg_true_dual) ||
        ((same_rdw_a != same_dont_care) && (same_rdw_b != same_dont_care));

    // Clock modes each configuration can carry with a known collision output.
    assign cfg_clk_ok = (cfg == cfg_true_dual) ?
        (clk_shared || (clk_mode == clk_independent)) : clk_shared;

    // Preloading only exists with an init image on a flash-capable variant.
    assign preload_ok = preload_en && flash_analog &&
        ((image_mode == img_comp_with_init) || (image_mode == img_uncomp_with_init));

    assign rdw_supported = same_sel_ok && cfg_clk_ok;
    assign preload_applied = preload_ok;

    // ------------------------------------------------------------------
    // Array storage
    // ------------------------------------------------------------------
    logic [data_w-1:0] mem [depth];
    wire logic both_same_addr;

    // A frozen input group drops its write along with its other inputs.
    always_comb begin
        for (int p = 0; p < port_count; p++) begin
            we_eff[p] = we_raw[p] && in_ce[p] && can_write[p];
            re_eff[p] = re_raw[p] && can_read[p];
        end
    end

    // No arbitration: two writes to one word leave it corrupt.
    assign both_same_addr = we_eff[0] && we_eff[1] && (addr[0] == addr[1]);

    // One process per word keeps a single driver per entry. The clear never
    // reaches here; only the power-up reset loads the starting contents.
    for (genvar i = 0; i < depth; i++) begin : g_word
        wire logic hit_a;
        wire logic hit_b;
        wire logic [data_w-1:0] start_word;

        assign hit_a = we_eff[0] && (addr[0] == addr_w'(i));
        assign hit_b = we_eff[1] && (addr[1] == addr_w'(i));
        assign start_word = preload_ok ?
            preload[i*data_w +: data_w] : {data_w{mem_reset_bit}};

        always_ff @(posedge clock) begin
            if (!nrst) begin
                mem[i] <= start_word;
            end else if (hit_a && hit_b) begin
                mem[i] <= {data_w{1'bx}};
            end else if (hit_a) begin
                mem[i] <= merged[0];
            end else if (hit_b) begin
                mem[i] <= merged[1];
            end
        end
    end

    // Sticky for one cycle only: marks the edge after a conflicting write pair.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            write_conflict <= flag_reset_bit;
        end else begin
            write_conflict <= both_same_addr;
        end
    end

    // ------------------------------------------------------------------
    // Read path per port
    // ------------------------------------------------------------------
    ram_port_if #(.data_w(data_w)) port_if [port_count] ();

    for (genvar p = 0; p < port_count; p++) begin : g_port
        localparam int other = port_count - 1 - p;
        wire logic own_hit;
        wire logic mix_hit;
        wire logic [data_w-1:0] same_word;
        wire logic [data_w-1:0] mixed_word;

        // Contents before this edge's writes, and the word as this port writes it.
        assign stored[p] = mem[addr[p]];
        assign merged[p] = lane_merge(stored[p], wdata[p], be[p]);

        // Same-port collision: this port reads the word it writes.
        assign own_hit = we_eff[p] && re_eff[p];

        // Mixed collision: the other port writes the word this port reads.
        assign mix_hit = we_eff[other] && re_eff[p] && (addr[other] == addr[p]);

        // New data flows through on the writing edge; old and don't care both
        // show the prior word. Outside legal clock modes the result is unknown.
        assign same_word = !same_clk_ok ? {data_w{1'bx}} :
            (same_mode[p] == same_new_data) ? merged[p] :
            stored[p];

        // Old data is only guaranteed when both ports see one edge; the read/write
        // and independent modes race the write, so the model refuses to guess.
        assign mixed_word = (mixed_clk_ok && (mixed_rdw == mixed_old_data)) ?
            stored[p] :
            {data_w{1'bx}};

        assign rd_word[p] = own_hit ? same_word : (mix_hit ? mixed_word : stored[p]);

        // Hand the port's control and read word to its output stage.
        assign port_if[p].in_ce = in_ce[p];
        assign port_if[p].re = re_eff[p];
        assign port_if[p].out_ce = out_ce[p];
        assign port_if[p].aclr = aclr[p];
        assign port_if[p].rd_word = rd_word[p];

        ram_port #(
            .out_reg((p == 0) ? out_reg_a : out_reg_b),
            .data_w(data_w)
        ) u_stage (
            .clock(clock),
            .nrst(nrst),
            .bus(port_if[p])
        );
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Read words come straight from each stage's flip-flops.
    assign a_q = port_if[0].q;
    assign b_q = port_if[1].q;
endmodule

/* block_ram_rdw_monitor.sv */
// Concurrent port checks for the block RAM read-during-write model.
`timescale 1ns/10ps
module block_ram_rdw_monitor #(
    parameter int data_w = ram_rdw_pkg::data_w_def,
    parameter int addr_w = ram_rdw_pkg::addr_w_def,
    parameter int byte_w = ram_rdw_pkg::byte_w_def
)(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [addr_w-1:0] a_addr,
    input wire logic [data_w-1:0] a_wdata,
    input wire logic [data_w/byte_w-1:0] a_be,
    input wire logic a_we,
    input wire logic a_re,
    input wire logic a_in_ce,
    input wire logic a_out_ce,
    input wire logic a_aclr,
    input wire logic [data_w-1:0] a_q,
    input wire logic [addr_w-1:0] b_addr,
    input wire logic b_we,
    input wire logic b_in_ce,
    input wire logic b_out_ce,
    input wire logic b_aclr,
    input wire logic [data_w-1:0] b_q,
    input wire logic write_conflict,
    input wire logic rdw_supported,
    input wire logic preload_applied
);
    import ram_rdw_pkg::*;
    // Both ports land on one word; a port A capture is judged only without it.
    wire both_wr = a_in_ce && b_in_ce && a_we && b_we && (a_addr == b_addr);
    wire a_rdw = nrst && a_in_ce && a_we && a_re && !a_aclr && !both_wr;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_new_word;
        a_rdw && (&a_be) ##1 (nrst && a_out_ce && !a_aclr) |=> a_aclr || a_q == $past(a_wdata, 2);
    endproperty
    a_new_word: assert property (p_new_word) else $error("written word not on a_q");
    property p_lane_pass;
        a_rdw && a_be[0] ##1 (nrst && a_out_ce && !a_aclr)
            |=> a_aclr || a_q[byte_w-1:0] == $past(a_wdata[byte_w-1:0], 2);
    endproperty
    a_lane_pass: assert property (p_lane_pass) else $error("enabled lane not on a_q");
    property p_reset_zero;
        $rose(nrst) |-> a_q == '0 && b_q == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("q not zero after reset");
    property p_clear;
        a_aclr || b_aclr |-> (!a_aclr || a_q == '0) && (!b_aclr || b_q == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("q not cleared by aclr");
    property p_out_hold;
        nrst && !a_out_ce && !a_aclr |=> a_aclr || $stable(a_q);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("a_q moved with out_ce low");
    property p_in_hold;
        nrst && !b_in_ce && b_out_ce && !b_aclr ##1 (b_out_ce && !b_aclr) |=> b_aclr || $stable(b_q);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("b_q moved with in_ce low");
    property p_conflict;
        nrst && $past(nrst) |-> write_conflict == $past(both_wr);
    endproperty
    a_conflict: assert property (p_conflict) else $error("write_conflict wrong");
    property p_modes;
        rdw_supported && !preload_applied;
    endproperty
    a_modes: assert property (p_modes) else $error("mode flags wrong");
endmodule
bind block_ram_rdw block_ram_rdw_monitor #(.data_w(data_w), .addr_w(addr_w), .byte_w(byte_w))
    block_ram_rdw_monitor_inst (.*);

/* ram_user_logic.sv */
// User-side drive model that keeps the far-side obligations.
`timescale 1ns/10ps
module ram_user_logic #(
    parameter int addr_w = ram_rdw_pkg::addr_w_def
)(
    input wire logic [addr_w-1:0] a_addr,
    input wire logic [addr_w-1:0] b_addr,
    input wire logic a_in_ce,
    input wire logic b_in_ce,
    input wire logic a_we_req,
    input wire logic b_we_req,
    input wire logic a_rd_need,
    input wire logic b_rd_need,
    input wire logic allow_clash,
    output logic a_we,
    output logic b_we,
    output logic a_re,
    output logic b_re
);
    // The array has no arbitration, so a port B write onto port A's word is
    // held back; the bench may lift this to provoke a clash on purpose.
    wire clash = a_we_req && b_we_req && a_in_ce && b_in_ce && (a_addr == b_addr);
    assign a_we = a_we_req;
    assign b_we = b_we_req && (allow_clash || !clash);
    // Read enable is raised only where a read word is wanted.
    assign a_re = a_rd_need;
    assign b_re = b_rd_need;
endmodule

/* tb.sv */
// Self-checking bench for the block RAM read-during-write model.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
    import ram_rdw_pkg::*;
    localparam int dw = data_w_def;
    localparam int aw = addr_w_def;
    localparam int bw = byte_w_def;
    localparam int lanes = data_w_def / byte_w_def;
    logic clock, nrst, allow_clash, a_we_req, b_we_req, a_rd_need, b_rd_need;
    logic a_we, b_we, a_re, b_re, write_conflict, rdw_supported, preload_applied;
    logic a_in_ce, b_in_ce, a_out_ce, b_out_ce, a_aclr, b_aclr;
    logic [aw-1:0] a_addr, b_addr;
    logic [dw-1:0] a_wdata, b_wdata, a_q, b_q, la, lb, qa, qb, a_q2, b_q2, la2, lb2, qa2, qb2;
    logic [lanes-1:0] a_be, b_be;
    logic [dw-1:0] mem [2**aw];
    logic wc;
    int n_errors, tests_run, seed;
    block_ram_rdw block_ram_rdw_inst (.*);
    ram_user_logic ram_user_logic_inst (.*);
    // Second copy on the same traffic: port B old data, mixed collisions unknown.
    // Port A stays new data so the bound checks hold for both copies.
    block_ram_rdw #(
        .clk_mode(clk_in_out),
        .same_rdw_b(same_old_data),
        .mixed_rdw(mixed_dont_care)
    ) block_ram_rdw_old_inst (
        .a_q(a_q2),
        .b_q(b_q2),
        .write_conflict(),
        .rdw_supported(),
        .preload_applied(),
        .*
    );
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // --------------------------------------------------------------
    // Reference model
    // --------------------------------------------------------------
    // Enabled lanes take the new bits, the others keep the stored ones.
    function automatic logic [dw-1:0] merge(input logic [dw-1:0] o, input logic [dw-1:0] n,
                                            input logic [lanes-1:0] be);
        merge = o;
        for (int l = 0; l < lanes; l++) begin
            if (be[l]) merge[l*bw+:bw] = n[l*bw+:bw];
        end
    endfunction
    // One rising edge of the model; old words are read before any write lands.
    task automatic step();
        logic wa, wb, clash, mixa, mixb;
        logic [dw-1:0] oa, ob;
        wa = a_in_ce && a_we;
        wb = b_in_ce && b_we;
        clash = wa && wb && a_addr == b_addr;
        oa = mem[a_addr];
        ob = mem[b_addr];
        mixa = wb && a_addr == b_addr;
        mixb = wa && a_addr == b_addr;
        if (!nrst) begin
            foreach (mem[i]) mem[i] = '0;
            {la, lb, qa, qb, wc, la2, lb2, qa2, qb2} = '0;
        end else begin
            qa = a_aclr ? '0 : a_out_ce ? la : qa;
            qb = b_aclr ? '0 : b_out_ce ? lb : qb;
            if (a_aclr) la = '0;
            else if (a_in_ce && a_re) la = wa ? merge(oa, a_wdata, a_be) : oa;
            if (b_aclr) lb = '0;
            else if (b_in_ce && b_re) lb = wb ? merge(ob, b_wdata, b_be) : ob;
            qa2 = a_aclr ? '0 : a_out_ce ? la2 : qa2;
            qb2 = b_aclr ? '0 : b_out_ce ? lb2 : qb2;
            if (a_aclr) la2 = '0;
            else if (a_in_ce && a_re) la2 = mixa && !wa ? 'x : la;
            if (b_aclr) lb2 = '0;
            else if (b_in_ce && b_re) lb2 = mixb && !wb ? 'x : ob;
            if (clash) mem[a_addr] = 'x;
            else begin
                if (wa) mem[a_addr] = merge(oa, a_wdata, a_be);
                if (wb) mem[b_addr] = merge(ob, b_wdata, b_be);
            end
            wc = clash;
        end
    endtask
    // Random port traffic, half the time on a few words so collisions are frequent.
    task automatic drive(input int mode);
        logic [31:0] r, s;
        r = $random(seed);
        s = $random(seed);
        {a_we_req, b_we_req} = r[1:0];
        a_rd_need = r[3:2] != 0;
        b_rd_need = r[5:4] != 0;
        a_in_ce = r[8:6] != 0;
        b_in_ce = r[11:9] != 0;
        a_out_ce = r[14:12] != 0;
        b_out_ce = r[17:15] != 0;
        a_aclr = r[22:18] == 0;
        b_aclr = r[27:23] == 0;
        a_be = r[29:28];
        b_be = r[31:30];
        a_addr = s[4] ? s[13:5] : aw'(s[1:0]);
        b_addr = s[14] ? s[23:15] : aw'(s[3:2]);
        a_wdata = dw'($random(seed));
        b_wdata = dw'($random(seed));
        allow_clash = mode == 2;
        if (mode == 2) begin
            {a_we_req, b_we_req, a_in_ce, b_in_ce, a_be, b_be} = '1;
            {a_rd_need, b_rd_need, a_aclr, b_aclr} = '0;
            b_addr = a_addr;
        end
    endtask
    // One cycle: model the edge, drive after it, compare once settled.
    task automatic tick(input int mode, input logic rst_n);
        @(posedge clock);
        step();
        #1;
        nrst = rst_n;
        drive(mode);
        if (a_aclr) {la, qa, la2, qa2} = '0;
        if (b_aclr) {lb, qb, lb2, qb2} = '0;
        #2;
        `CHK("a_q", qa, a_q)
        `CHK("b_q", qb, b_q)
        `CHK("write_conflict", wc, write_conflict)
        `CHK("a_q2", qa2, a_q2)
        `CHK("b_q2", qb2, b_q2)
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // A hung run is cut short and counted as a mismatch.
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
    initial begin
        seed = 32'h06a6;
        nrst = 1'b0;
        drive(0);
        repeat (15) tick(0, 1'b0);
        `CHK("rdw_supported", 1'b1, rdw_supported)
        `CHK("preload_applied", 1'b0, preload_applied)
        $display("test reset done");
        repeat (2000) tick(0, 1'b1);
        $display("test random_traffic done");
        tick(2, 1'b1);
        repeat (200) tick(0, 1'b1);
        $display("test write_clash done");
        repeat (3) tick(0, 1'b0);
        repeat (500) tick(0, 1'b1);
        $display("test second_reset done");
        stop_test();
    end
endmodule
